//--- fbsa_pkg.sv
// constants, types and register map of the fieldbus slave alarm checker
package fbsa_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS = 1000000;
    localparam int MS_CYC = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLINK_MS = 200;
    localparam int FLICKER_MS = 50;
    localparam int DFLASH_ON_MS = 200;
    localparam int DFLASH_GAP_MS = 200;
    localparam int DFLASH_OFF_MS = 1000;
    localparam logic [10:0] BLINK_PER = 11'(2 * BLINK_MS);
    localparam logic [10:0] BLINK_ON = 11'(BLINK_MS);
    localparam logic [10:0] FLICK_PER = 11'(2 * FLICKER_MS);
    localparam logic [10:0] FLICK_ON = 11'(FLICKER_MS);
    localparam logic [10:0] DFL_ON1 = 11'(DFLASH_ON_MS);
    localparam logic [10:0] DFL_ON2_B = 11'(DFLASH_ON_MS + DFLASH_GAP_MS);
    localparam logic [10:0] DFL_ON2_E =
        11'(2 * DFLASH_ON_MS + DFLASH_GAP_MS);
    localparam logic [10:0] DFL_PER =
        11'(2 * DFLASH_ON_MS + DFLASH_GAP_MS + DFLASH_OFF_MS);

    // ------------------------------------------------------------
    // register map (word index, byte address is four times it)
    // ------------------------------------------------------------
    localparam logic [13:0] IDX_IRQ_STAT = 14'h3740;
    localparam logic [13:0] IDX_IRQ_MASK = 14'h3741;
    localparam logic [13:0] IDX_ALM_CLR = 14'h3742;
    localparam logic [13:0] IDX_TIMEOUT = 14'h3743;
    localparam logic [13:0] IDX_ALM_STAT = 14'h3744;
    localparam logic [15:0] TIMEOUT_RST = 16'h0000;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam int TIMEOUT_SIGN = 15;

    // ------------------------------------------------------------
    // protocol values
    // ------------------------------------------------------------
    localparam logic [7:0] MAP_MAX_BYTES = 8'h20;
    localparam logic [15:0] AL_TX_MAP = 16'h0024;
    localparam logic [15:0] AL_RX_MAP = 16'h0025;
    localparam logic [15:0] AL_LINK = 16'h0000;
    localparam logic [15:0] AL_EEPROM = 16'h0051;
    localparam logic [15:0] AL_NONE = 16'h0000;
    localparam logic [3:0] ESM_INIT = 4'h1;
    localparam logic [3:0] ESM_PREOP = 4'h2;
    localparam logic [3:0] ESM_SAFEOP = 4'h4;
    localparam logic [3:0] ESM_OP = 4'h8;
    localparam logic [1:0] SYNC_OTHER = 2'h3;
    localparam int EE_ERR_LO = 11;
    localparam int EE_ERR_HI = 14;
    localparam int NPORT = 2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LED_OFF,
        LED_BLINK,
        LED_DFLASH,
        LED_FLICKER
    } fbsa_led_pat_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } fbsa_bus_st_t;

    typedef struct packed {
        logic ee;
        logic link;
        logic rx;
        logic tx;
    } fbsa_alarms_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [13:0] idx;
        logic [31:0] wdata;
        logic [3:0] be;
    } fbsa_avm_req_t;

endpackage

//--- fbsa_err_led.sv
// error indicator pattern generator
`timescale 1ns/10ps
`default_nettype none
module fbsa_err_led (
    input wire logic clk,
    input wire logic rst,
    input wire logic ms_tick,
    input wire fbsa_pkg::fbsa_led_pat_t pattern,
    output logic led
);
    fbsa_pkg::fbsa_led_pat_t pat_q;
    logic [10:0] ph_q;
    logic [10:0] per;
    logic on_d;

    always_comb begin
        per = fbsa_pkg::BLINK_PER;
        on_d = 1'b0;
        unique case (pat_q)
            fbsa_pkg::LED_OFF: begin
                per = fbsa_pkg::BLINK_PER;
                on_d = 1'b0;
            end
            fbsa_pkg::LED_BLINK: begin
                per = fbsa_pkg::BLINK_PER;
                on_d = ph_q < fbsa_pkg::BLINK_ON;
            end
            fbsa_pkg::LED_FLICKER: begin
                per = fbsa_pkg::FLICK_PER;
                on_d = ph_q < fbsa_pkg::FLICK_ON;
            end
            fbsa_pkg::LED_DFLASH: begin
                per = fbsa_pkg::DFL_PER;
                on_d = (ph_q < fbsa_pkg::DFL_ON1) ||
                    (ph_q >= fbsa_pkg::DFL_ON2_B &&
                    ph_q < fbsa_pkg::DFL_ON2_E);
            end
        endcase
    end

    // restart the phase whenever the pattern changes
    always_ff @(posedge clk) begin
        if (rst) begin
            pat_q <= fbsa_pkg::LED_OFF;
            ph_q <= 11'h000;
        end else if (pattern != pat_q) begin
            pat_q <= pattern;
            ph_q <= 11'h000;
        end else if (ms_tick) begin
            ph_q <= (ph_q + 11'h001 >= per) ? 11'h000 : ph_q + 11'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            led <= 1'b0;
        end else begin
            led <= on_d;
        end
    end

    a_led_dark_off: assert property (@(posedge clk) disable iff (rst)
        pat_q == fbsa_pkg::LED_OFF |=> !led)
        else $error("indicator lit with no alarm");
endmodule // fbsa_err_led
`default_nettype wire

//--- fbsa_alarm_checker.sv
// alarm checker top: map size, link loss and eeprom alarms, avalon regs
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - On a PreOP to SafeOP request in DC, FreeRun or SM2 mode a transmit map over 32 bytes latches an alarm, forces PreOP, reports 0024h and blinks the indicator.
// - On a PreOP to SafeOP request in any mode a receive map over 32 bytes latches an alarm, forces PreOP, reports 0025h and blinks the indicator.
// - After Init to PreOP a port that stays down longer than the programmed time latches the link alarm, forces Init, reports 0000h and double flashes.
// - A port already down at the Init to PreOP step is not supervised.
// - The timeout is a signed 16-bit count of milliseconds, 0 to 32767, and zero turns link supervision off.
// - The timeout resets to zero so supervision starts disabled.
// - Only this slave's own lost port can raise the link alarm.
// - In any state an identity mismatch with the eeprom latches the eeprom alarm, forces Init, reports 0051h and flickers.
// - A failed eeprom read or write also raises the eeprom alarm.
// - Any of bits 11 to 14 set in the eeprom control/status word raises the eeprom alarm.
module fbsa_alarm_checker #(
    parameter int MS_CYCLES = fbsa_pkg::MS_CYC
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [15:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    input wire logic [3:0] ESM_STATE,
    input wire logic SAFEOP_REQ,
    input wire logic [1:0] SYNC_MODE,
    input wire logic [7:0] TX_MAP_BYTES,
    input wire logic [7:0] RX_MAP_BYTES,
    input wire logic [1:0] PORT_LINK_UP,
    input wire logic EE_ID_MISMATCH,
    input wire logic EE_ACCESS_FAIL,
    input wire logic [15:0] EE_CTRL_STAT,
    output logic FORCE_VALID,
    output logic [3:0] FORCE_STATE,
    output logic [15:0] AL_STATUS_CODE,
    output logic ERR_LED,
    output logic IRQ
);
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    fbsa_pkg::fbsa_avm_req_t req;
    fbsa_pkg::fbsa_bus_st_t bus_q;
    fbsa_pkg::fbsa_alarms_t alm_q;
    fbsa_pkg::fbsa_alarms_t evt;
    fbsa_pkg::fbsa_alarms_t new_alm;
    fbsa_pkg::fbsa_alarms_t irq_stat_q;
    fbsa_pkg::fbsa_alarms_t irq_mask_q;
    logic [15:0] timeout_q;
    logic wr_done;
    logic rd_done;
    logic clr_wr;
    logic [31:0] rd_d;

    assign req = '{read: READ, write: WRITE, idx: ADDRESS[15:2],
        wdata: WRITEDATA, be: BYTEENABLE};
    assign wr_done = (bus_q == fbsa_pkg::BUS_ACK) && req.write;
    assign rd_done = (bus_q == fbsa_pkg::BUS_ACK) && req.read;
    assign clr_wr = wr_done && req.idx == fbsa_pkg::IDX_ALM_CLR &&
        req.be[0];

    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (req.idx)
            fbsa_pkg::IDX_IRQ_STAT: rd_d = {28'h0000000, irq_stat_q};
            fbsa_pkg::IDX_IRQ_MASK: rd_d = {28'h0000000, irq_mask_q};
            fbsa_pkg::IDX_TIMEOUT: rd_d = {16'h0000, timeout_q};
            fbsa_pkg::IDX_ALM_STAT: rd_d = {28'h0000000, alm_q};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // one wait cycle, then the answer stands for the completing edge
    always_ff @(posedge MCLK) begin
        if (RST) begin
            bus_q <= fbsa_pkg::BUS_IDLE;
            WAITREQUEST <= 1'b1;
            READDATA <= 32'h0000_0000;
        end else begin
            unique case (bus_q)
                fbsa_pkg::BUS_IDLE: begin
                    if (req.read || req.write) begin
                        bus_q <= fbsa_pkg::BUS_ACK;
                        WAITREQUEST <= 1'b0;
                        READDATA <= req.read ? rd_d : 32'h0000_0000;
                    end
                end
                fbsa_pkg::BUS_ACK: begin
                    bus_q <= fbsa_pkg::BUS_IDLE;
                    WAITREQUEST <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            timeout_q <= fbsa_pkg::TIMEOUT_RST;
        end else if (wr_done && req.idx == fbsa_pkg::IDX_TIMEOUT) begin
            if (req.be[0]) begin
                timeout_q[7:0] <= req.wdata[7:0];
            end
            if (req.be[1]) begin
                timeout_q[15:8] <= req.wdata[15:8];
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            irq_mask_q <= fbsa_pkg::MASK_RST;
        end else if (wr_done && req.idx == fbsa_pkg::IDX_IRQ_MASK &&
            req.be[0]) begin
            irq_mask_q <= req.wdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // port link synchronisers and supervision
    // ------------------------------------------------------------
    logic [fbsa_pkg::NPORT-1:0] lk_s1_q;
    logic [fbsa_pkg::NPORT-1:0] lk_s2_q;
    logic [fbsa_pkg::NPORT-1:0] lk_s3_q;
    logic [fbsa_pkg::NPORT-1:0] link_up_q;
    logic [fbsa_pkg::NPORT-1:0] mon_q;
    logic [fbsa_pkg::NPORT-1:0] port_exp;
    logic [3:0] esm_prev_q;
    logic [15:0] ms_cnt_q;
    logic ms_tick;
    logic sup_on;
    logic to_on;
    logic link_evt;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            lk_s1_q <= '0;
            lk_s2_q <= '0;
            lk_s3_q <= '0;
            link_up_q <= '0;
        end else begin
            lk_s1_q <= PORT_LINK_UP;
            lk_s2_q <= lk_s1_q;
            lk_s3_q <= lk_s2_q;
            link_up_q <= (lk_s2_q & ~(lk_s2_q ^ lk_s3_q)) |
                (link_up_q & (lk_s2_q ^ lk_s3_q));
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ms_cnt_q <= 16'h0000;
        end else if (ms_cnt_q == 16'(MS_CYCLES - 1)) begin
            ms_cnt_q <= 16'h0000;
        end else begin
            ms_cnt_q <= ms_cnt_q + 16'h0001;
        end
    end
    assign ms_tick = ms_cnt_q == 16'(MS_CYCLES - 1);

    always_ff @(posedge MCLK) begin
        if (RST) begin
            esm_prev_q <= fbsa_pkg::ESM_INIT;
        end else begin
            esm_prev_q <= ESM_STATE;
        end
    end

    assign sup_on = ESM_STATE == fbsa_pkg::ESM_PREOP ||
        ESM_STATE == fbsa_pkg::ESM_SAFEOP || ESM_STATE == fbsa_pkg::ESM_OP;
    assign to_on = timeout_q != 16'h0000 &&
        !timeout_q[fbsa_pkg::TIMEOUT_SIGN];

    // ports that were up at the Init to PreOP step are watched
    always_ff @(posedge MCLK) begin
        if (RST) begin
            mon_q <= '0;
        end else if (esm_prev_q == fbsa_pkg::ESM_INIT &&
            ESM_STATE == fbsa_pkg::ESM_PREOP) begin
            mon_q <= link_up_q;
        end else if (!sup_on) begin
            mon_q <= '0;
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < fbsa_pkg::NPORT; gp++) begin : g_port
            logic [15:0] down_ms_q;
            always_ff @(posedge MCLK) begin
                if (RST || link_up_q[gp] || !mon_q[gp]) begin
                    down_ms_q <= 16'h0000;
                end else if (ms_tick && down_ms_q != 16'hffff) begin
                    down_ms_q <= down_ms_q + 16'h0001;
                end
            end
            // only this slave's own port counts
            assign port_exp[gp] = mon_q[gp] && !link_up_q[gp] &&
                down_ms_q > timeout_q;
        end
    endgenerate

    assign link_evt = sup_on && to_on && (|port_exp);

    // ------------------------------------------------------------
    // alarm detection and latching
    // ------------------------------------------------------------
    logic ee_evt;
    assign ee_evt = EE_ID_MISMATCH || EE_ACCESS_FAIL ||
        (|EE_CTRL_STAT[fbsa_pkg::EE_ERR_HI:fbsa_pkg::EE_ERR_LO]);

    assign evt.tx = SAFEOP_REQ && ESM_STATE == fbsa_pkg::ESM_PREOP &&
        SYNC_MODE != fbsa_pkg::SYNC_OTHER &&
        TX_MAP_BYTES > fbsa_pkg::MAP_MAX_BYTES;
    assign evt.rx = SAFEOP_REQ && ESM_STATE == fbsa_pkg::ESM_PREOP &&
        RX_MAP_BYTES > fbsa_pkg::MAP_MAX_BYTES;
    assign evt.link = link_evt;
    assign evt.ee = ee_evt;
    assign new_alm = evt & ~alm_q;

    // set wins over clear; the eeprom alarm cannot be cleared
    always_ff @(posedge MCLK) begin
        if (RST) begin
            alm_q <= '0;
        end else begin
            alm_q.tx <= evt.tx || (alm_q.tx && !(clr_wr && req.wdata[0]));
            alm_q.rx <= evt.rx || (alm_q.rx && !(clr_wr && req.wdata[1]));
            alm_q.link <= evt.link ||
                (alm_q.link && !(clr_wr && req.wdata[2]));
            alm_q.ee <= evt.ee || alm_q.ee;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            FORCE_VALID <= 1'b0;
            FORCE_STATE <= fbsa_pkg::ESM_INIT;
        end else begin
            FORCE_VALID <= |new_alm;
            if (new_alm.ee || new_alm.link) begin
                FORCE_STATE <= fbsa_pkg::ESM_INIT;
            end else if (new_alm.rx || new_alm.tx) begin
                FORCE_STATE <= fbsa_pkg::ESM_PREOP;
            end
        end
    end

    // ------------------------------------------------------------
    // status code, indicator and interrupt
    // ------------------------------------------------------------
    fbsa_pkg::fbsa_led_pat_t pat;
    always_comb begin
        if (alm_q.ee) begin
            pat = fbsa_pkg::LED_FLICKER;
        end else if (alm_q.link) begin
            pat = fbsa_pkg::LED_DFLASH;
        end else if (alm_q.rx || alm_q.tx) begin
            pat = fbsa_pkg::LED_BLINK;
        end else begin
            pat = fbsa_pkg::LED_OFF;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            AL_STATUS_CODE <= fbsa_pkg::AL_NONE;
        end else if (alm_q.ee) begin
            AL_STATUS_CODE <= fbsa_pkg::AL_EEPROM;
        end else if (alm_q.link) begin
            AL_STATUS_CODE <= fbsa_pkg::AL_LINK;
        end else if (alm_q.rx) begin
            AL_STATUS_CODE <= fbsa_pkg::AL_RX_MAP;
        end else if (alm_q.tx) begin
            AL_STATUS_CODE <= fbsa_pkg::AL_TX_MAP;
        end else begin
            AL_STATUS_CODE <= fbsa_pkg::AL_NONE;
        end
    end

    fbsa_err_led u_led (
        .clk(MCLK),
        .rst(RST),
        .ms_tick(ms_tick),
        .pattern(pat),
        .led(ERR_LED)
    );

    // read of the status clears it, a new event in that cycle survives
    always_ff @(posedge MCLK) begin
        if (RST) begin
            irq_stat_q <= '0;
        end else if (rd_done && req.idx == fbsa_pkg::IDX_IRQ_STAT) begin
            irq_stat_q <= new_alm;
        end else begin
            irq_stat_q <= irq_stat_q | new_alm;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |((irq_stat_q | new_alm) & irq_mask_q &
                ~({4{rd_done && req.idx == fbsa_pkg::IDX_IRQ_STAT}} &
                ~new_alm));
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence s_to_preop;
        FORCE_VALID && FORCE_STATE == fbsa_pkg::ESM_PREOP;
    endsequence
    sequence s_to_init;
        FORCE_VALID && FORCE_STATE == fbsa_pkg::ESM_INIT;
    endsequence

    a_tx_map_alarm: assert property (
        new_alm.tx && !new_alm.link && !new_alm.ee |=> s_to_preop ##1
        (AL_STATUS_CODE == fbsa_pkg::AL_TX_MAP || alm_q.rx || alm_q.ee ||
        alm_q.link))
        else $error("transmit map alarm not handled");
    a_rx_map_alarm: assert property (
        new_alm.rx && !new_alm.link && !new_alm.ee |=> s_to_preop ##1
        (AL_STATUS_CODE == fbsa_pkg::AL_RX_MAP || alm_q.ee || alm_q.link))
        else $error("receive map alarm not handled");
    a_link_force_init: assert property (
        new_alm.link |=> s_to_init ##0 alm_q.link)
        else $error("link alarm did not force init");
    a_link_unwatched: assert property (
        mon_q == '0 |-> !link_evt)
        else $error("link alarm from unwatched port");
    a_link_disabled: assert property (
        timeout_q == 16'h0000 |-> !link_evt)
        else $error("link alarm with zero timeout");
    a_timeout_reset: assert property (
        $past(RST) |-> timeout_q == 16'h0000)
        else $error("timeout not zero after reset");
    a_link_local: assert property (
        link_evt |-> |(mon_q & ~link_up_q))
        else $error("link alarm without own lost port");
    a_ee_id_alarm: assert property (
        EE_ID_MISMATCH && !alm_q.ee |=> s_to_init ##1
        AL_STATUS_CODE == fbsa_pkg::AL_EEPROM)
        else $error("identity mismatch not handled");
    a_ee_access_fail: assert property (
        EE_ACCESS_FAIL |=> alm_q.ee)
        else $error("eeprom access failure missed");
    a_ee_ctrl_bits: assert property (
        |EE_CTRL_STAT[14:11] |=> alm_q.ee)
        else $error("eeprom status bits missed");
    a_ee_no_clear: assert property (
        alm_q.ee |=> alm_q.ee [*2])
        else $error("eeprom alarm was cleared");
    a_map_clear: assert property (
        clr_wr && req.wdata[0] && !evt.tx |=> !alm_q.tx)
        else $error("transmit map alarm not cleared");
    a_bus_answer: assert property (
        (READ || WRITE) && bus_q == fbsa_pkg::BUS_IDLE |=> !WAITREQUEST
        ##1 WAITREQUEST)
        else $error("bus answer not in one cycle");
endmodule // fbsa_alarm_checker
`default_nettype wire

//--- fbsa_far_end.sv
// far-end model: network master stepping the slave state machine
`timescale 1ns/10ps
`default_nettype none
module fbsa_far_end (
    input wire logic clk,
    input wire logic force_valid,
    input wire logic [3:0] force_state,
    output logic [3:0] esm,
    output logic safeop_req,
    output logic [1:0] sync,
    output logic [7:0] tx_bytes,
    output logic [7:0] rx_bytes,
    output logic [1:0] link_up
);
    initial begin
        esm = fbsa_pkg::ESM_INIT;
        safeop_req = 1'b0;
        sync = 2'h0;
        tx_bytes = 8'h20;
        rx_bytes = 8'h20;
        link_up = 2'h3;
    end
    // ------------------------------------------------------------
    // state steps and safeop requests
    // ------------------------------------------------------------
    task automatic go(input logic [3:0] s, input logic [1:0] l);
        @(posedge clk);
        esm <= s;
        link_up <= l;
    endtask
    task automatic ask(input logic [1:0] m, input logic [7:0] t,
        input logic [7:0] r);
        @(posedge clk);
        sync <= m;
        tx_bytes <= t;
        rx_bytes <= r;
        safeop_req <= 1'b1;
    endtask
    // forced state is obeyed and the request withdrawn
    always @(posedge clk) begin
        if (force_valid) begin
            esm <= force_state;
            safeop_req <= 1'b0;
        end
    end
endmodule // fbsa_far_end
`default_nettype wire

//--- tb.sv
// self-checking bench for the alarm checker
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int MSC = 10;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic [15:0] ADDRESS = 16'h0000;
    logic READ = 1'b0;
    logic WRITE = 1'b0;
    logic [31:0] WRITEDATA = 32'h0;
    logic [31:0] READDATA;
    logic [31:0] rd;
    logic WAITREQUEST;
    logic [3:0] ESM_STATE;
    logic SAFEOP_REQ;
    logic [1:0] SYNC_MODE;
    logic [7:0] TX_MAP_BYTES;
    logic [7:0] RX_MAP_BYTES;
    logic [1:0] PORT_LINK_UP;
    logic [15:0] EE_CTRL_STAT = 16'h0;
    logic EE_ID_MISMATCH = 1'b0;
    logic EE_ACCESS_FAIL = 1'b0;
    logic FORCE_VALID;
    logic [3:0] FORCE_STATE;
    logic [15:0] AL_STATUS_CODE;
    logic ERR_LED;
    logic IRQ;
    int n_errors = 0;
    int checks = 0;
    int waited;
    fbsa_alarm_checker #(.MS_CYCLES(MSC)) dut (.MCLK(MCLK), .RST(RST),
        .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
        .WRITEDATA(WRITEDATA), .BYTEENABLE(4'h3), .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST), .ESM_STATE(ESM_STATE),
        .SAFEOP_REQ(SAFEOP_REQ), .SYNC_MODE(SYNC_MODE),
        .TX_MAP_BYTES(TX_MAP_BYTES), .RX_MAP_BYTES(RX_MAP_BYTES),
        .PORT_LINK_UP(PORT_LINK_UP), .EE_ID_MISMATCH(EE_ID_MISMATCH),
        .EE_ACCESS_FAIL(EE_ACCESS_FAIL), .EE_CTRL_STAT(EE_CTRL_STAT),
        .FORCE_VALID(FORCE_VALID), .FORCE_STATE(FORCE_STATE),
        .AL_STATUS_CODE(AL_STATUS_CODE), .ERR_LED(ERR_LED), .IRQ(IRQ));
    fbsa_far_end fe (.clk(MCLK), .force_valid(FORCE_VALID),
        .force_state(FORCE_STATE), .esm(ESM_STATE),
        .safeop_req(SAFEOP_REQ), .sync(SYNC_MODE),
        .tx_bytes(TX_MAP_BYTES), .rx_bytes(RX_MAP_BYTES),
        .link_up(PORT_LINK_UP));
    initial begin
        forever #10 MCLK = ~MCLK;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    task automatic bus(input logic w, input logic [13:0] i,
        input logic [31:0] d);
        int k;
        @(posedge MCLK);
        ADDRESS <= {i, 2'b00};
        READ <= !w;
        WRITE <= w;
        WRITEDATA <= d;
        k = 0;
        do begin
            @(posedge MCLK);
            k++;
        end while (WAITREQUEST !== 1'b0 && k < 50);
        if (WAITREQUEST !== 1'b0) begin
            n_errors++;
            test_done();
        end
        rd = READDATA;
        READ <= 1'b0;
        WRITE <= 1'b0;
    endtask
    task automatic rdc(input logic [13:0] i, input logic [31:0] e);
        bus(1'b0, i, 32'h0);
        chk("register", e, rd);
    endtask
    task automatic wforce(input logic [3:0] s);
        for (waited = 0; waited < 300 && FORCE_VALID !== 1'b1; waited++)
            tick(1);
        if (waited == 300) begin
            n_errors++;
            test_done();
        end
        chk("force state", {28'h0, s}, {28'h0, FORCE_STATE});
        tick(2);
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge MCLK);
        RST <= 1'b0;
        rdc(fbsa_pkg::IDX_TIMEOUT, 32'h0);
        rdc(fbsa_pkg::IDX_ALM_STAT, 32'h0);
        rdc(14'h0000, 32'h0);
        $display("test reset done");
        fe.go(fbsa_pkg::ESM_INIT, 2'h1);
        tick(10);
        fe.go(fbsa_pkg::ESM_PREOP, 2'h1);
        tick(10);
        fe.go(fbsa_pkg::ESM_PREOP, 2'h0);
        tick(60);
        rdc(fbsa_pkg::IDX_ALM_STAT, 32'h0);
        fe.go(fbsa_pkg::ESM_PREOP, 2'h1);
        tick(10);
        bus(1'b1, fbsa_pkg::IDX_TIMEOUT, 32'h3);
        rdc(fbsa_pkg::IDX_TIMEOUT, 32'h3);
        tick(60);
        rdc(fbsa_pkg::IDX_ALM_STAT, 32'h0);
        fe.go(fbsa_pkg::ESM_PREOP, 2'h0);
        wforce(fbsa_pkg::ESM_INIT);
        chk("down time", 32'h1, {31'h0, waited >= 3 * MSC});
        chk("al code", 32'h0, {16'h0, AL_STATUS_CODE});
        chk("led", 32'h1, {31'h0, ERR_LED});
        chk("irq", 32'h0, {31'h0, IRQ});
        rdc(fbsa_pkg::IDX_ALM_STAT, 32'h4);
        bus(1'b1, fbsa_pkg::IDX_ALM_CLR, 32'h7);
        rdc(fbsa_pkg::IDX_ALM_STAT, 32'h0);
        $display("test link done");
        fe.go(fbsa_pkg::ESM_PREOP, 2'h3);
        fe.ask(2'h0, 8'h20, 8'h20);
        tick(10);
        rdc(fbsa_pkg::IDX_ALM_STAT, 32'h0);
        fe.ask(2'h0, 8'h21, 8'h20);
        wforce(fbsa_pkg::ESM_PREOP);
        chk("al code", 32'h24, {16'h0, AL_STATUS_CODE});
        chk("led", 32'h1, {31'h0, ERR_LED});
        bus(1'b1, fbsa_pkg::IDX_ALM_CLR, 32'h7);
        fe.ask(2'h3, 8'h21, 8'h20);
        tick(10);
        rdc(fbsa_pkg::IDX_ALM_STAT, 32'h0);
        fe.ask(2'h3, 8'h20, 8'h21);
        wforce(fbsa_pkg::ESM_PREOP);
        chk("al code", 32'h25, {16'h0, AL_STATUS_CODE});
        bus(1'b1, fbsa_pkg::IDX_ALM_CLR, 32'h7);
        tick(4);
        chk("led", 32'h0, {31'h0, ERR_LED});
        $display("test map done");
        rdc(fbsa_pkg::IDX_IRQ_STAT, 32'h7);
        // one eeprom fault source per pass, reset between passes
        for (int s = 0; s < 3; s++) begin
            if (s > 0) begin
                @(posedge MCLK);
                RST <= 1'b1;
                repeat (2) @(posedge MCLK);
                RST <= 1'b0;
                rdc(fbsa_pkg::IDX_TIMEOUT, 32'h0);
            end
            bus(1'b1, fbsa_pkg::IDX_IRQ_MASK, 32'h8);
            @(posedge MCLK);
            EE_ID_MISMATCH <= s == 0;
            EE_ACCESS_FAIL <= s == 1;
            EE_CTRL_STAT <= (s == 2) ? 16'h0800 : 16'h0000;
            wforce(fbsa_pkg::ESM_INIT);
            chk("al code", 32'h51, {16'h0, AL_STATUS_CODE});
            chk("irq", 32'h1, {31'h0, IRQ});
            chk("led", 32'h1, {31'h0, ERR_LED});
            @(posedge MCLK);
            EE_ID_MISMATCH <= 1'b0;
            EE_ACCESS_FAIL <= 1'b0;
            EE_CTRL_STAT <= 16'h0000;
            tick(55 * MSC);
            chk("led", 32'h0, {31'h0, ERR_LED});
            bus(1'b1, fbsa_pkg::IDX_ALM_CLR, 32'hf);
            rdc(fbsa_pkg::IDX_ALM_STAT, 32'h8);
        end
        rdc(fbsa_pkg::IDX_IRQ_STAT, 32'h8);
        rdc(fbsa_pkg::IDX_IRQ_STAT, 32'h0);
        tick(2);
        chk("irq", 32'h0, {31'h0, IRQ});
        $display("test eeprom done");
        test_done();
    end
endmodule // tb
`default_nettype wire
